// file: rtl/bsf_pkg.sv
package bsf_pkg;

    // Register byte offsets
    localparam logic [7:0] ADDR_CMD    = 8'h00;
    localparam logic [7:0] ADDR_WORK   = 8'h04;
    localparam logic [7:0] ADDR_IO     = 8'h08;
    localparam logic [7:0] ADDR_FLAGS  = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;

    // Field positions
    localparam int CMD_OP_LSB   = 0;
    localparam int CMD_BIT_LSB  = 5;
    localparam int ST_BUSY      = 0;
    localparam int ST_FULL      = 1;
    localparam int ST_EMPTY     = 2;
    localparam int ST_REFUSED   = 3;

    // Status flag positions inside the flags register
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;

    // Values after reset
    localparam logic [7:0] WORK_RST  = 8'h00;
    localparam logic [7:0] IO_RST    = 8'h00;
    localparam logic [7:0] FLAGS_RST = 8'h00;

    // Operation codes
    localparam logic [4:0] OP_NOP        = 5'h00;
    localparam logic [4:0] OP_PUSH       = 5'h01;
    localparam logic [4:0] OP_POP        = 5'h02;
    localparam logic [4:0] OP_IO_SET     = 5'h03;
    localparam logic [4:0] OP_IO_CLEAR   = 5'h04;
    localparam logic [4:0] OP_SHIFT_L    = 5'h05;
    localparam logic [4:0] OP_SHIFT_R    = 5'h06;
    localparam logic [4:0] OP_ROT_L      = 5'h07;
    localparam logic [4:0] OP_ROT_R      = 5'h08;
    localparam logic [4:0] OP_ARITH_R    = 5'h09;
    localparam logic [4:0] OP_SWAP       = 5'h0a;
    localparam logic [4:0] OP_FLAG_SET   = 5'h0b;
    localparam logic [4:0] OP_FLAG_CLEAR = 5'h0c;
    localparam logic [4:0] OP_BIT_STORE  = 5'h0d;
    localparam logic [4:0] OP_BIT_LOAD   = 5'h0e;
    localparam logic [4:0] OP_CARRY_SET  = 5'h0f;
    localparam logic [4:0] OP_CARRY_CLR  = 5'h10;
    localparam logic [4:0] OP_NEG_SET    = 5'h11;
    localparam logic [4:0] OP_NEG_CLR    = 5'h12;
    localparam logic [4:0] OP_ZERO_SET   = 5'h13;
    localparam logic [4:0] OP_ZERO_CLR   = 5'h14;
    localparam logic [4:0] OP_IRQ_ON     = 5'h15;
    localparam logic [4:0] OP_IRQ_OFF    = 5'h16;

    // Execution cycle counts
    localparam logic [1:0] CYC_ONE = 2'h1;
    localparam logic [1:0] CYC_TWO = 2'h2;

    // Stack geometry
    localparam int STACK_DEPTH = 16;
    localparam int STACK_PTR_W = 5;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic {PH_IDLE, PH_EXEC} bsf_phase_t;

endpackage

// file: rtl/bsf_shift_unit.sv
`timescale 1ns/10ps
`default_nettype none

module bsf_shift_unit (
    // Operation
    input  wire logic [4:0] op,
    input  wire logic [7:0] din,
    input  wire logic       cin,
    // Result
    output logic      [7:0] dout,
    output logic            cout,
    output logic            zout,
    output logic            nout,
    output logic            vout
);

    always_comb begin
        dout = din;
        cout = cin;
        case (op)
            bsf_pkg::OP_SHIFT_L: begin
                dout = {din[6:0], 1'b0};
                cout = din[7];
            end
            bsf_pkg::OP_SHIFT_R: begin
                dout = {1'b0, din[7:1]};
                cout = din[0];
            end
            bsf_pkg::OP_ROT_L: begin
                dout = {din[6:0], cin};
                cout = din[7];
            end
            bsf_pkg::OP_ROT_R: begin
                dout = {cin, din[7:1]};
                cout = din[0];
            end
            bsf_pkg::OP_ARITH_R: begin
                dout = {din[7], din[7:1]};
                cout = din[0];
            end
            default: begin
                dout = din;
                cout = cin;
            end
        endcase
        zout = (dout == 8'h00);
        nout = dout[7];
        // Overflow follows sign change against carry out
        vout = dout[7] ^ cout;
    end

endmodule

`default_nettype wire

// file: rtl/bsf_stack.sv
`timescale 1ns/10ps
`default_nettype none

module bsf_stack (
    // Clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Access
    input  wire logic       push,
    input  wire logic       pop,
    input  wire logic [7:0] wdata,
    output logic      [7:0] top,
    output logic            full,
    output logic            empty
);

    typedef struct packed {
        logic [bsf_pkg::STACK_PTR_W-1:0] sp;
    } bsf_stack_t;

    bsf_stack_t st_ff;
    bsf_stack_t nxt_st;
    logic [7:0] mem [bsf_pkg::STACK_DEPTH];

    localparam logic [bsf_pkg::STACK_PTR_W-1:0] SP_FULL =
        bsf_pkg::STACK_PTR_W'(bsf_pkg::STACK_DEPTH);
    localparam logic [bsf_pkg::STACK_PTR_W-1:0] SP_ONE = 5'h01;

    assign full  = (st_ff.sp == SP_FULL);
    assign empty = (st_ff.sp == '0);
    assign top   = empty ? 8'h00 : mem[st_ff.sp[3:0] - 4'h1];

    always_comb begin
        nxt_st = st_ff;
        if (push && !full) begin
            nxt_st.sp = st_ff.sp + SP_ONE;
        end else if (pop && !empty) begin
            nxt_st.sp = st_ff.sp - SP_ONE;
        end
    end

    // Storage has no reset; only the pointer matters
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
        if (push && !full) begin
            mem[st_ff.sp[3:0]] <= wdata;
        end
    end

endmodule

`default_nettype wire

// file: rtl/bsf_core.sv
`timescale 1ns/10ps
`default_nettype none

// Function
// - push copies register to stack, two cycles
// - pop loads register from stack, two cycles
// - io bit set, other bits kept
// - io bit clear, other bits kept
// - left shift, zero in, ZCNV updated
// - right shift, zero in, ZCNV updated
// - rotate left through carry, ZCNV updated
// - rotate right through carry, ZCNV updated
// - arithmetic right shift keeps bit seven
// - nibble swap, flags untouched, one cycle
// - generic flag set or clear by index
// - register bit copied into transfer flag
// - transfer flag copied into register bit
// - set or clear carry or negative, one flag per op
// - set or clear zero flag only
// - set or clear global interrupt enable
module bsf_core (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Write address
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] awaddr,
    input  wire logic [2:0]  awprot,
    // Write data
    input  wire logic        wvalid,
    output logic             wready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    // Write response
    output logic             bvalid,
    input  wire logic        bready,
    output logic      [1:0]  bresp,
    // Read address
    input  wire logic        arvalid,
    output logic             arready,
    input  wire logic [31:0] araddr,
    input  wire logic [2:0]  arprot,
    // Read data
    output logic             rvalid,
    input  wire logic        rready,
    output logic      [31:0] rdata,
    output logic      [1:0]  rresp
);

    typedef struct packed {
        logic                awready;
        logic                wready;
        logic                bvalid;
        logic [1:0]          bresp;
        logic                arready;
        logic                rvalid;
        logic [31:0]         rdata;
        logic [1:0]          rresp;
        bsf_pkg::bsf_phase_t phase;
        logic [1:0]          left;
        logic [4:0]          op;
        logic [2:0]          bidx;
        logic [7:0]          work;
        logic [7:0]          io;
        logic [7:0]          flags;
        logic                refused;
    } bsf_state_t;

    bsf_state_t st_ff;
    bsf_state_t nxt_st;

    logic       wr_fire;
    logic       rd_fire;
    logic       wr_map;
    logic       rd_map;
    logic       busy;
    logic       commit;
    logic       two_cyc;
    logic       stk_push;
    logic       stk_pop;
    logic [7:0] stk_top;
    logic       stk_full;
    logic       stk_empty;
    logic [7:0] sh_dout;
    logic       sh_c;
    logic       sh_z;
    logic       sh_n;
    logic       sh_v;
    logic       is_shift;
    logic [31:0] status_word;

    ////////////////////////////////////////////////////////////////////////
    // Submodules

    bsf_shift_unit u_shift (
        .op   (st_ff.op),
        .din  (st_ff.work),
        .cin  (st_ff.flags[bsf_pkg::FLAG_C]),
        .dout (sh_dout),
        .cout (sh_c),
        .zout (sh_z),
        .nout (sh_n),
        .vout (sh_v)
    );

    bsf_stack u_stack (
        .aclk    (aclk),
        .aresetn (aresetn),
        .push    (stk_push),
        .pop     (stk_pop),
        .wdata   (st_ff.work),
        .top     (stk_top),
        .full    (stk_full),
        .empty   (stk_empty)
    );

    ////////////////////////////////////////////////////////////////////////
    // Decode helpers

    assign wr_fire = st_ff.awready && awvalid && wvalid;
    assign rd_fire = st_ff.arready && arvalid;
    assign wr_map  = (awaddr[31:8] == 24'h000000) && (awaddr[1:0] == 2'h0) &&
                     (awaddr[7:0] <= bsf_pkg::ADDR_STATUS);
    assign rd_map  = (araddr[31:8] == 24'h000000) && (araddr[1:0] == 2'h0) &&
                     (araddr[7:0] <= bsf_pkg::ADDR_STATUS);
    assign busy    = (st_ff.phase == bsf_pkg::PH_EXEC);
    assign commit  = busy && (st_ff.left == bsf_pkg::CYC_ONE);
    assign two_cyc = (st_ff.op == bsf_pkg::OP_PUSH) || (st_ff.op == bsf_pkg::OP_POP) ||
                     (st_ff.op == bsf_pkg::OP_IO_SET) || (st_ff.op == bsf_pkg::OP_IO_CLEAR);
    assign is_shift = (st_ff.op >= bsf_pkg::OP_SHIFT_L) && (st_ff.op <= bsf_pkg::OP_ARITH_R);
    assign stk_push = commit && (st_ff.op == bsf_pkg::OP_PUSH);
    assign stk_pop  = commit && (st_ff.op == bsf_pkg::OP_POP);

    assign status_word = {28'h0000000, st_ff.refused, stk_empty, stk_full, busy};

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        nxt_st = st_ff;
        // Ready only once both channels wait, so one handshake edge takes both
        nxt_st.awready = awvalid && wvalid && !st_ff.awready && !st_ff.bvalid;
        nxt_st.wready  = awvalid && wvalid && !st_ff.awready && !st_ff.bvalid;
        nxt_st.arready = arvalid && !st_ff.arready && !st_ff.rvalid;
        if (st_ff.bvalid && bready) begin
            nxt_st.bvalid = 1'b0;
        end
        if (st_ff.rvalid && rready) begin
            nxt_st.rvalid = 1'b0;
        end

        // Execution sequencer
        if (busy) begin
            nxt_st.left = st_ff.left - 2'h1;
        end
        if (commit) begin
            nxt_st.phase = bsf_pkg::PH_IDLE;
            if (is_shift) begin
                nxt_st.work                 = sh_dout;
                nxt_st.flags[bsf_pkg::FLAG_C] = sh_c;
                nxt_st.flags[bsf_pkg::FLAG_Z] = sh_z;
                nxt_st.flags[bsf_pkg::FLAG_N] = sh_n;
                nxt_st.flags[bsf_pkg::FLAG_V] = sh_v;
            end
            case (st_ff.op)
                bsf_pkg::OP_PUSH: begin
                    if (stk_full) begin
                        nxt_st.refused = 1'b1;
                    end
                end
                bsf_pkg::OP_POP: begin
                    if (stk_empty) begin
                        nxt_st.refused = 1'b1;
                    end else begin
                        nxt_st.work = stk_top;
                    end
                end
                bsf_pkg::OP_IO_SET:     nxt_st.io[st_ff.bidx] = 1'b1;
                bsf_pkg::OP_IO_CLEAR:   nxt_st.io[st_ff.bidx] = 1'b0;
                bsf_pkg::OP_SWAP:       nxt_st.work = {st_ff.work[3:0], st_ff.work[7:4]};
                bsf_pkg::OP_FLAG_SET:   nxt_st.flags[st_ff.bidx] = 1'b1;
                bsf_pkg::OP_FLAG_CLEAR: nxt_st.flags[st_ff.bidx] = 1'b0;
                bsf_pkg::OP_BIT_STORE:  nxt_st.flags[bsf_pkg::FLAG_T] = st_ff.work[st_ff.bidx];
                bsf_pkg::OP_BIT_LOAD:   nxt_st.work[st_ff.bidx] = st_ff.flags[bsf_pkg::FLAG_T];
                bsf_pkg::OP_CARRY_SET:  nxt_st.flags[bsf_pkg::FLAG_C] = 1'b1;
                bsf_pkg::OP_CARRY_CLR:  nxt_st.flags[bsf_pkg::FLAG_C] = 1'b0;
                bsf_pkg::OP_NEG_SET:    nxt_st.flags[bsf_pkg::FLAG_N] = 1'b1;
                bsf_pkg::OP_NEG_CLR:    nxt_st.flags[bsf_pkg::FLAG_N] = 1'b0;
                bsf_pkg::OP_ZERO_SET:   nxt_st.flags[bsf_pkg::FLAG_Z] = 1'b1;
                bsf_pkg::OP_ZERO_CLR:   nxt_st.flags[bsf_pkg::FLAG_Z] = 1'b0;
                bsf_pkg::OP_IRQ_ON:     nxt_st.flags[bsf_pkg::FLAG_I] = 1'b1;
                bsf_pkg::OP_IRQ_OFF:    nxt_st.flags[bsf_pkg::FLAG_I] = 1'b0;
                default: begin
                end
            endcase
        end

        // Register writes; data registers are frozen while an op runs
        if (wr_fire) begin
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp  = wr_map ? bsf_pkg::RESP_OKAY : bsf_pkg::RESP_SLVERR;
            if (wr_map && wstrb[0]) begin
                case (awaddr[7:0])
                    bsf_pkg::ADDR_CMD: begin
                        if (busy) begin
                            nxt_st.refused = 1'b1;
                        end else begin
                            nxt_st.op    = wdata[bsf_pkg::CMD_OP_LSB +: 5];
                            nxt_st.bidx  = wdata[bsf_pkg::CMD_BIT_LSB +: 3];
                            nxt_st.phase = bsf_pkg::PH_EXEC;
                            nxt_st.left  =
                                ((wdata[4:0] == bsf_pkg::OP_PUSH) ||
                                 (wdata[4:0] == bsf_pkg::OP_POP) ||
                                 (wdata[4:0] == bsf_pkg::OP_IO_SET) ||
                                 (wdata[4:0] == bsf_pkg::OP_IO_CLEAR)) ?
                                bsf_pkg::CYC_TWO : bsf_pkg::CYC_ONE;
                        end
                    end
                    bsf_pkg::ADDR_WORK: begin
                        if (busy) nxt_st.refused = 1'b1;
                        else nxt_st.work = wdata[7:0];
                    end
                    bsf_pkg::ADDR_IO: begin
                        if (busy) nxt_st.refused = 1'b1;
                        else nxt_st.io = wdata[7:0];
                    end
                    bsf_pkg::ADDR_FLAGS: begin
                        if (busy) nxt_st.refused = 1'b1;
                        else nxt_st.flags = wdata[7:0];
                    end
                    bsf_pkg::ADDR_STATUS: begin
                        // Write one clears; a refusal in the same cycle wins
                        if (wdata[bsf_pkg::ST_REFUSED] && !(busy && commit &&
                            ((stk_push && stk_full) || (stk_pop && stk_empty)))) begin
                            nxt_st.refused = 1'b0;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end

        // Register reads
        if (rd_fire) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp  = rd_map ? bsf_pkg::RESP_OKAY : bsf_pkg::RESP_SLVERR;
            case (araddr[7:0])
                bsf_pkg::ADDR_CMD:    nxt_st.rdata = {24'h000000, st_ff.bidx, st_ff.op};
                bsf_pkg::ADDR_WORK:   nxt_st.rdata = {24'h000000, st_ff.work};
                bsf_pkg::ADDR_IO:     nxt_st.rdata = {24'h000000, st_ff.io};
                bsf_pkg::ADDR_FLAGS:  nxt_st.rdata = {24'h000000, st_ff.flags};
                bsf_pkg::ADDR_STATUS: nxt_st.rdata = status_word;
                default:              nxt_st.rdata = 32'h00000000;
            endcase
            if (!rd_map) begin
                nxt_st.rdata = 32'h00000000;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff       <= '0;
            st_ff.work  <= bsf_pkg::WORK_RST;
            st_ff.io    <= bsf_pkg::IO_RST;
            st_ff.flags <= bsf_pkg::FLAGS_RST;
            st_ff.phase <= bsf_pkg::PH_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign awready = st_ff.awready;
    assign wready  = st_ff.wready;
    assign bvalid  = st_ff.bvalid;
    assign bresp   = st_ff.bresp;
    assign arready = st_ff.arready;
    assign rvalid  = st_ff.rvalid;
    assign rdata   = st_ff.rdata;
    assign rresp   = st_ff.rresp;

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking dflt_cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    two_cycle_ops_a : assert property (
        (!busy && wr_fire && awaddr[7:0] == bsf_pkg::ADDR_CMD && wstrb[0] &&
         wdata[4:0] >= bsf_pkg::OP_PUSH && wdata[4:0] <= bsf_pkg::OP_IO_CLEAR)
        |=> busy [*2] ##1 !busy)
        else $error("two-cycle op did not last two cycles");

    one_cycle_ops_a : assert property (
        (!busy && wr_fire && awaddr[7:0] == bsf_pkg::ADDR_CMD && wstrb[0] &&
         wdata[4:0] >= bsf_pkg::OP_SHIFT_L && wdata[4:0] <= bsf_pkg::OP_IRQ_OFF)
        |=> busy ##1 !busy)
        else $error("one-cycle op did not last one cycle");

    stack_flags_a : assert property (
        (commit && two_cyc && !wr_fire)
        |=> st_ff.flags == $past(st_ff.flags))
        else $error("stack op changed flags");

    pop_value_a : assert property (
        (commit && st_ff.op == bsf_pkg::OP_POP && !stk_empty)
        |=> st_ff.work == $past(stk_top))
        else $error("pop loaded wrong value");

    io_set_a : assert property (
        (commit && st_ff.op == bsf_pkg::OP_IO_SET)
        |=> st_ff.io == ($past(st_ff.io) | (8'h01 << $past(st_ff.bidx))))
        else $error("io bit set wrong");

    shift_left_a : assert property (
        (commit && st_ff.op == bsf_pkg::OP_SHIFT_L && !wr_fire)
        |=> st_ff.work == {$past(st_ff.work[6:0]), 1'b0} &&
            st_ff.flags[bsf_pkg::FLAG_C] == $past(st_ff.work[7]))
        else $error("left shift wrong");

    rotate_carry_a : assert property (
        (commit && st_ff.op == bsf_pkg::OP_ROT_L && !wr_fire)
        |=> st_ff.work[0] == $past(st_ff.flags[bsf_pkg::FLAG_C]) &&
            st_ff.flags[bsf_pkg::FLAG_C] == $past(st_ff.work[7]))
        else $error("rotate left wrong");

    arith_sign_a : assert property (
        (commit && st_ff.op == bsf_pkg::OP_ARITH_R && !wr_fire)
        |=> st_ff.work[7] == $past(st_ff.work[7]) &&
            st_ff.work[6:0] == $past(st_ff.work[7:1]))
        else $error("arithmetic shift wrong");

    bit_store_a : assert property (
        (commit && st_ff.op == bsf_pkg::OP_BIT_STORE && !wr_fire)
        |=> st_ff.flags[bsf_pkg::FLAG_T] == $past(st_ff.work[st_ff.bidx]) &&
            st_ff.flags[5:0] == $past(st_ff.flags[5:0]))
        else $error("bit store wrong");

    irq_enable_a : assert property (
        (commit && st_ff.op == bsf_pkg::OP_IRQ_ON && !wr_fire)
        |=> st_ff.flags == ($past(st_ff.flags) | 8'h80))
        else $error("interrupt enable wrong");

endmodule

`default_nettype wire

// file: sim/testbench.sv
`timescale 1ns/10ps
`default_nettype none

module testbench;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic [31:0] awaddr = 32'h0;
    logic [31:0] araddr = 32'h0;
    logic [31:0] wdata = 32'h0;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  bresp;
    logic [1:0]  rresp;
    int          n_fail = 0;
    int          checked = 0;

    always #5 aclk = ~aclk;

    bsf_core dut_u (
        .aclk(aclk), .aresetn(aresetn),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hf),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", s, e, g);
        end
    endtask

    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        awaddr <= {24'h0, a};
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk("bresp", 32'(er), 32'(bresp));
        @(posedge aclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
        araddr <= {24'h0, a};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        rready <= 1'b0;
        chk("rresp", 32'(er), 32'(rresp));
        @(posedge aclk);
    endtask

    task automatic rc(input string s, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        rd(a, bsf_pkg::RESP_OKAY, d);
        chk(s, e, d);
    endtask

    // Busy is polled; the watchdog bounds a hang
    task automatic ex(input logic [4:0] op, input logic [2:0] b);
        logic [31:0] d;
        wr(bsf_pkg::ADDR_CMD, {b, op}, bsf_pkg::RESP_OKAY);
        do rd(bsf_pkg::ADDR_STATUS, bsf_pkg::RESP_OKAY, d);
        while (d[bsf_pkg::ST_BUSY] !== 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rc("work", bsf_pkg::ADDR_WORK, 32'(bsf_pkg::WORK_RST));
        rc("io", bsf_pkg::ADDR_IO, 32'(bsf_pkg::IO_RST));
        rc("flags", bsf_pkg::ADDR_FLAGS, 32'(bsf_pkg::FLAGS_RST));
        rc("status", bsf_pkg::ADDR_STATUS, 32'h4);
    endtask

    // Shift family on mixed values, carry both ways; upper flags must survive
    task automatic t_shift;
        logic [7:0] v[3] = '{8'h96, 8'h01, 8'h80};
        logic [8:0] r;
        logic [7:0] f;
        logic [4:0] op;
        for (int k = 0; k < 15; k++) begin
            f = 8'h70 | 8'(k & 1);
            op = bsf_pkg::OP_SHIFT_L + 5'(k % 5);
            case (k % 5)
                0: r = {v[k / 5], 1'b0};
                1: r = {v[k / 5][0], 1'b0, v[k / 5][7:1]};
                2: r = {v[k / 5], f[0]};
                3: r = {v[k / 5][0], f[0], v[k / 5][7:1]};
                default: r = {v[k / 5][0], v[k / 5][7], v[k / 5][7:1]};
            endcase
            wr(bsf_pkg::ADDR_WORK, v[k / 5], bsf_pkg::RESP_OKAY);
            wr(bsf_pkg::ADDR_FLAGS, f, bsf_pkg::RESP_OKAY);
            ex(op, 3'h0);
            f[3:0] = {r[7] ^ r[8], r[7], r[7:0] == 8'h0, r[8]};
            rc("shift", bsf_pkg::ADDR_WORK, 32'(r[7:0]));
            rc("shflag", bsf_pkg::ADDR_FLAGS, 32'(f));
        end
    endtask

    task automatic t_flag;
        int         fi[4] = '{bsf_pkg::FLAG_C, bsf_pkg::FLAG_N, bsf_pkg::FLAG_Z, bsf_pkg::FLAG_I};
        logic [7:0] f;
        for (int k = 0; k < 8; k++) begin
            f = k[0] ? 8'hff : 8'h00;
            wr(bsf_pkg::ADDR_FLAGS, f, bsf_pkg::RESP_OKAY);
            f[fi[k / 2]] = ~f[fi[k / 2]];
            ex(bsf_pkg::OP_CARRY_SET + 5'(k), 3'h0);
            rc("oneflag", bsf_pkg::ADDR_FLAGS, 32'(f));
        end
        for (int b = 0; b < 8; b++) begin
            wr(bsf_pkg::ADDR_FLAGS, 8'h00, bsf_pkg::RESP_OKAY);
            ex(bsf_pkg::OP_FLAG_SET, 3'(b));
            rc("fset", bsf_pkg::ADDR_FLAGS, 32'h1 << b);
            wr(bsf_pkg::ADDR_FLAGS, 8'hff, bsf_pkg::RESP_OKAY);
            ex(bsf_pkg::OP_FLAG_CLEAR, 3'(b));
            rc("fclr", bsf_pkg::ADDR_FLAGS, 32'hff & ~(32'h1 << b));
        end
    endtask

    task automatic t_bits;
        wr(bsf_pkg::ADDR_FLAGS, 8'hff, bsf_pkg::RESP_OKAY);
        wr(bsf_pkg::ADDR_WORK, 8'ha5, bsf_pkg::RESP_OKAY);
        ex(bsf_pkg::OP_BIT_STORE, 3'h1);
        rc("tstore0", bsf_pkg::ADDR_FLAGS, 32'hbf);
        ex(bsf_pkg::OP_BIT_STORE, 3'h0);
        rc("tstore1", bsf_pkg::ADDR_FLAGS, 32'hff);
        ex(bsf_pkg::OP_BIT_LOAD, 3'h6);
        rc("tload", bsf_pkg::ADDR_WORK, 32'he5);
        wr(bsf_pkg::ADDR_WORK, 8'h1e, bsf_pkg::RESP_OKAY);
        ex(bsf_pkg::OP_SWAP, 3'h0);
        rc("swap", bsf_pkg::ADDR_WORK, 32'he1);
        rc("swflag", bsf_pkg::ADDR_FLAGS, 32'hff);
    endtask

    // Pop on an empty stack is the awkward case; the refusal is sticky
    task automatic t_stack;
        wr(bsf_pkg::ADDR_FLAGS, 8'h3c, bsf_pkg::RESP_OKAY);
        wr(bsf_pkg::ADDR_WORK, 8'h5a, bsf_pkg::RESP_OKAY);
        ex(bsf_pkg::OP_PUSH, 3'h0);
        rc("stpush", bsf_pkg::ADDR_STATUS, 32'h0);
        wr(bsf_pkg::ADDR_WORK, 8'h00, bsf_pkg::RESP_OKAY);
        ex(bsf_pkg::OP_POP, 3'h0);
        rc("pop", bsf_pkg::ADDR_WORK, 32'h5a);
        ex(bsf_pkg::OP_POP, 3'h0);
        rc("stempty", bsf_pkg::ADDR_STATUS, 32'hc);
        wr(bsf_pkg::ADDR_STATUS, 8'h08, bsf_pkg::RESP_OKAY);
        rc("stclr", bsf_pkg::ADDR_STATUS, 32'h4);
        wr(bsf_pkg::ADDR_IO, 8'h00, bsf_pkg::RESP_OKAY);
        ex(bsf_pkg::OP_IO_SET, 3'h3);
        ex(bsf_pkg::OP_IO_SET, 3'h7);
        rc("ioset", bsf_pkg::ADDR_IO, 32'h88);
        ex(bsf_pkg::OP_IO_CLEAR, 3'h3);
        rc("ioclr", bsf_pkg::ADDR_IO, 32'h80);
        rc("stflag", bsf_pkg::ADDR_FLAGS, 32'h3c);
        // Fill past depth; the extra push is refused and pops come back last in first out
        for (int k = 0; k < 17; k++) begin
            wr(bsf_pkg::ADDR_WORK, 8'(k + 8'h20), bsf_pkg::RESP_OKAY);
            ex(bsf_pkg::OP_PUSH, 3'h0);
        end
        rc("stfull", bsf_pkg::ADDR_STATUS, 32'ha);
        for (int k = 16; k > 0; k--) begin
            ex(bsf_pkg::OP_POP, 3'h0);
            rc("lifo", bsf_pkg::ADDR_WORK, 32'(k + 31));
        end
        rc("stdrain", bsf_pkg::ADDR_STATUS, 32'hc);
    endtask

    task automatic t_unmap;
        logic [31:0] d;
        rd(8'h14, bsf_pkg::RESP_SLVERR, d);
        chk("unmapped", 32'h0, d);
        rd(8'h02, bsf_pkg::RESP_SLVERR, d);
        chk("unaligned", 32'h0, d);
        wr(8'h14, 8'hff, bsf_pkg::RESP_SLVERR);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic test_done;
        $display("checks %0d errors %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset;
        t_shift;
        t_flag;
        t_bits;
        t_stack;
        t_unmap;
        test_done;
    end

    // Whole run is well under two thousand cycles; 20000 leaves wide margin
    initial begin
        repeat (20000) @(posedge aclk);
        n_fail++;
        test_done;
    end
endmodule

`default_nettype wire
